/* hdl/master_port_stage.v */
// One outbound write-address stage for a master port.
// Assumes the port's input and output clock enables come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module master_port_stage #(
   parameter PAYLOAD_W = 64
) (
   input  wire                 clk,
   input  wire                 arst_n,
   input  wire                 in_clk_en,
   input  wire                 out_clk_en,
   input  wire                 load_valid,
   input  wire [PAYLOAD_W-1:0] load_payload,
   output wire                 load_ready,
   output reg                  port_valid,
   output reg  [PAYLOAD_W-1:0] port_payload,
   input  wire                 port_ready
);

   reg  taken;   // Handshake seen on an input edge, not yet retired
   wire done;

   // *****
   // Handshake bookkeeping
   // *****
   // Ready only counts on input-enabled edges; retire on output edges
   assign done       = port_valid & (taken | (in_clk_en & port_ready));
   assign load_ready = out_clk_en & (~port_valid | done);

   // Outbound signals change only on output-enabled edges
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_valid   <= 1'b0;
         port_payload <= {PAYLOAD_W{1'b0}};
         taken        <= 1'b0;
      end else if (out_clk_en) begin
         if (!port_valid || done) begin
            port_valid   <= load_valid;
            port_payload <= load_payload;
            taken        <= 1'b0;
         end
      end else if (in_clk_en && port_valid && port_ready) begin
         taken <= 1'b1;   // Keep the beat so a slow output edge cannot replay it
      end
   end

endmodule // master_port_stage

`default_nettype wire

/* hdl/wr_route_defs.vh */
// Constants for the master-port write routing block.
// Assumes inclusion by bare name from the design files under hdl/.
//
// What this block does
// - Core writes drive user bits: 8 early response, 7 zero line, 6 clean, 5 L1, 0 shared.
// - Core writes carry inner attributes in user bits 4 to 1.
// - Coherency port writes zero user bits 8:5 and pass bits 4:0 through.
// - Filter enable, start and end registers load their pins on reset exit.
// - With filtering on, in-range accesses go to port one, all others port zero.
// - With filtering off, locked and exclusive accesses always use port zero.
// - With filtering off, device forcing sends every device-type access to port zero.
// - Filtering wins over device forcing for in-range device accesses.
// - Master ports run integer and half-integer ratios through clock enables.
// - Optional 64-bit coherency slave port for non-caching masters.
// - Outbound write ID bit 2 is 0 for cores, 1 for coherency port.
// - Coherency port uses integer ratios only, one slave clock enable.
`ifndef WR_ROUTE_DEFS_VH
`define WR_ROUTE_DEFS_VH

// *****
// Register map (byte addresses)
// *****
`define REG_CTRL          4'h0
`define REG_FILTER_LOW    4'h4
`define REG_FILTER_HIGH   4'h8
`define REG_ISSUE_COUNT   4'hc

// *****
// Control register fields
// *****
`define CTRL_FILTER_EN_BIT   1
`define CTRL_DEV_FORCE_BIT   3
`define CTRL_RESET           32'h0000_0000

// *****
// Write user bit fields and encodings
// *****
`define USER_EARLY_RESP_BIT  8
`define USER_ZERO_LINE_BIT   7
`define USER_CLEAN_EVICT_BIT 6
`define USER_L1_EVICT_BIT    5
`define USER_SHARED_BIT      0
`define ATTR_STRONG_ORDER    4'b0000
`define ATTR_DEVICE          4'b0001
`define ATTR_NORMAL_NC       4'b0011
`define ATTR_WRITE_THROUGH   4'b0110
`define ATTR_WB_NO_ALLOC     4'b0111
`define ATTR_WB_ALLOC        4'b1111
`define COH_USER_HIGH_ZERO   4'b0000

// *****
// ID field, lock encodings, bus answers, timing
// *****
`define ID_SOURCE_BIT        2
`define LOCK_EXCLUSIVE       2'b01
`define LOCK_LOCKED          2'b10
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`define PIN_SETTLE_CYCLES    2'd3

`endif

/* hdl/write_route.v */
// Write-address router for two outbound master ports, with user bit
// composition, address filtering, device forcing and an AXI4-Lite
// register slave. Assumes all inputs except the filter pins are on clk.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wr_route_defs.vh"

module write_route #(
   parameter ADDR_W     = 32,
   parameter SPLIT_BIT  = 5    // Address bit that spreads unfiltered traffic
) (
   input  wire              clk,
   input  wire              arst_n,
   // Filter straps
   input  wire              addr_filter_enable_pin,
   input  wire [ADDR_W-1:0] addr_filter_low_pin,
   input  wire [ADDR_W-1:0] addr_filter_high_pin,
   // Core write request
   input  wire              core_aw_valid,
   output reg               core_aw_ready,
   input  wire [ADDR_W-1:0] core_aw_addr,
   input  wire [1:0]        core_aw_cpu,
   input  wire [2:0]        core_aw_kind,
   input  wire [3:0]        core_aw_attr,
   input  wire              core_aw_shared,
   input  wire              core_aw_early_resp,
   input  wire              core_aw_zero_line,
   input  wire              core_aw_clean_evict,
   input  wire              core_aw_l1_evict,
   input  wire [1:0]        core_aw_lock,
   // Coherency slave port write request
   input  wire              coherency_port_clk_en,
   input  wire              coh_aw_valid,
   output reg               coh_aw_ready,
   input  wire [ADDR_W-1:0] coh_aw_addr,
   input  wire [2:0]        coh_aw_id,
   input  wire [4:0]        coherency_port_write_user_in,
   input  wire [1:0]        coh_aw_lock,
   // Master port zero
   input  wire              port0_input_clk_en,
   input  wire              port0_output_clk_en,
   output wire              m0_aw_valid,
   input  wire              m0_aw_ready,
   output wire [ADDR_W-1:0] m0_aw_addr,
   output wire [5:0]        m0_write_id,
   output wire [8:0]        m0_write_user_bits,
   output wire [1:0]        m0_aw_lock,
   // Master port one
   input  wire              port1_input_clk_en,
   input  wire              port1_output_clk_en,
   output wire              m1_aw_valid,
   input  wire              m1_aw_ready,
   output wire [ADDR_W-1:0] m1_aw_addr,
   output wire [5:0]        m1_write_id,
   output wire [8:0]        m1_write_user_bits,
   output wire [1:0]        m1_aw_lock,
   // AXI4-Lite register slave
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [3:0]        s_axi_awaddr,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   output reg  [1:0]        s_axi_bresp,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   input  wire [3:0]        s_axi_araddr,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp
);

   localparam PAYLOAD_W = ADDR_W + 6 + 9 + 2;

   // *****
   // Functions
   // *****
   // Byte-enable merge for register writes
   function [31:0] merge_bytes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      integer      b;
      begin
         merge_bytes = old_val;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // True for an exclusive or locked access
   function is_locked;
      input [1:0] lock;
      begin
         is_locked = (lock == `LOCK_EXCLUSIVE) || (lock == `LOCK_LOCKED);
      end
   endfunction

   // *****
   // Strap synchronisers and capture on reset exit
   // *****
   reg              en_sync1;
   reg              en_sync2;
   reg [ADDR_W-1:0] low_sync1;
   reg [ADDR_W-1:0] low_sync2;
   reg [ADDR_W-1:0] high_sync1;
   reg [ADDR_W-1:0] high_sync2;
   reg [1:0]        settle_cnt;
   reg              straps_loaded;

   // Two flops before anything looks at the pins
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_sync1   <= 1'b0;
         en_sync2   <= 1'b0;
         low_sync1  <= {ADDR_W{1'b0}};
         low_sync2  <= {ADDR_W{1'b0}};
         high_sync1 <= {ADDR_W{1'b0}};
         high_sync2 <= {ADDR_W{1'b0}};
      end else begin
         en_sync1   <= addr_filter_enable_pin;
         en_sync2   <= en_sync1;
         low_sync1  <= addr_filter_low_pin;
         low_sync2  <= low_sync1;
         high_sync1 <= addr_filter_high_pin;
         high_sync2 <= high_sync1;
      end
   end

   // Wait for the synchronisers to fill before trusting the straps
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settle_cnt    <= 2'd0;
         straps_loaded <= 1'b0;
      end else if (!straps_loaded) begin
         settle_cnt    <= settle_cnt + 2'd1;
         straps_loaded <= (settle_cnt == `PIN_SETTLE_CYCLES);
      end
   end

   // *****
   // Registers
   // *****
   reg  [31:0]       ctrl;
   reg  [ADDR_W-1:0] filter_low;
   reg  [ADDR_W-1:0] filter_high;
   reg  [15:0]       issued0;
   reg  [15:0]       issued1;
   reg               aw_held;
   reg  [3:0]        aw_addr_held;
   reg               w_held;
   reg  [31:0]       w_data_held;
   reg  [3:0]        w_strb_held;
   wire              wr_fire;
   wire              wr_mapped;

   assign wr_fire   = aw_held & w_held & ~s_axi_bvalid;
   assign wr_mapped = (aw_addr_held == `REG_CTRL) || (aw_addr_held == `REG_FILTER_LOW)
                    || (aw_addr_held == `REG_FILTER_HIGH);

   // Address and data taken in either order; answer once both are in
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_held       <= 1'b0;
         aw_addr_held  <= 4'h0;
         w_held        <= 1'b0;
         w_data_held   <= 32'h0000_0000;
         w_strb_held   <= 4'h0;
      end else begin
         s_axi_awready <= straps_loaded & ~aw_held & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= straps_loaded & ~w_held & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held      <= 1'b1;
            aw_addr_held <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held      <= 1'b1;
            w_data_held <= s_axi_wdata;
            w_strb_held <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   // Strap capture first, then software writes; both stay legal
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl        <= `CTRL_RESET;
         filter_low  <= {ADDR_W{1'b0}};
         filter_high <= {ADDR_W{1'b0}};
      end else if (!straps_loaded) begin
         ctrl[`CTRL_FILTER_EN_BIT] <= en_sync2;
         filter_low                <= low_sync2;
         filter_high               <= high_sync2;
      end else if (wr_fire) begin
         if (aw_addr_held == `REG_CTRL) begin
            ctrl <= merge_bytes(ctrl, w_data_held, w_strb_held);
         end else if (aw_addr_held == `REG_FILTER_LOW) begin
            filter_low <= merge_bytes(filter_low, w_data_held, w_strb_held);
         end else if (aw_addr_held == `REG_FILTER_HIGH) begin
            filter_high <= merge_bytes(filter_high, w_data_held, w_strb_held);
         end
      end
   end

   // Read channel: one cycle from address to data
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (s_axi_araddr == `REG_CTRL) begin
               s_axi_rdata <= ctrl;
            end else if (s_axi_araddr == `REG_FILTER_LOW) begin
               s_axi_rdata <= filter_low;
            end else if (s_axi_araddr == `REG_FILTER_HIGH) begin
               s_axi_rdata <= filter_high;
            end else if (s_axi_araddr == `REG_ISSUE_COUNT) begin
               s_axi_rdata <= {issued1, issued0};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // *****
   // Request holding slots
   // *****
   reg                 core_held;
   reg [PAYLOAD_W-1:0] core_payload;
   reg                 coh_held;
   reg [PAYLOAD_W-1:0] coh_payload;
   reg                 last_coh;   // Fairness: coherency port won last time
   wire                core_take;
   wire                coh_take;
   wire                core_win;
   wire                coh_win;
   wire                grant;

   assign core_take = core_aw_valid & core_aw_ready;
   assign coh_take  = coherency_port_clk_en & coh_aw_valid & coh_aw_ready;

   // Compose outbound id and user bits as each request is taken
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_payload <= {PAYLOAD_W{1'b0}};
         coh_payload  <= {PAYLOAD_W{1'b0}};
      end else begin
         if (core_take) begin
            core_payload <= {core_aw_addr,
                             core_aw_kind, 1'b0, core_aw_cpu,
                             core_aw_early_resp, core_aw_zero_line,
                             core_aw_clean_evict, core_aw_l1_evict,
                             core_aw_attr,
                             core_aw_shared,
                             core_aw_lock};
         end
         if (coh_take) begin
            // Low user bits pass as given; the far master picks its encoding
            coh_payload <= {coh_aw_addr,
                            coh_aw_id, 1'b1, 2'b00,
                            `COH_USER_HIGH_ZERO,
                            coherency_port_write_user_in,
                            coh_aw_lock};
         end
      end
   end

   // *****
   // Routing decision
   // *****
   wire [PAYLOAD_W-1:0] sel_payload;
   wire [ADDR_W-1:0]    sel_addr;
   wire [3:0]           sel_attr;
   wire [1:0]           sel_lock;
   wire                 in_range;
   wire                 want_one;
   wire                 load0_ready;
   wire                 load1_ready;
   wire                 sel_ready;

   assign core_win    = core_held & (~coh_held | last_coh);
   assign coh_win     = coh_held & ~core_win;
   assign sel_payload = core_win ? core_payload : coh_payload;
   assign sel_addr    = sel_payload[PAYLOAD_W-1 -: ADDR_W];
   assign sel_attr    = sel_payload[6:3];
   assign sel_lock    = sel_payload[1:0];
   assign in_range    = (sel_addr >= filter_low) && (sel_addr <= filter_high);

   // Filtering overrides device forcing and every attribute
   assign want_one = ctrl[`CTRL_FILTER_EN_BIT] ? in_range :
                     is_locked(sel_lock) ? 1'b0 :
                     (ctrl[`CTRL_DEV_FORCE_BIT]
                        && sel_attr == `ATTR_DEVICE) ? 1'b0 :
                     sel_addr[SPLIT_BIT];   // Same address, same port: order kept

   assign sel_ready = want_one ? load1_ready : load0_ready;
   assign grant     = (core_held | coh_held) & sel_ready;

   // Slots empty on grant; ready flags mirror the next slot state
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_held     <= 1'b0;
         coh_held      <= 1'b0;
         core_aw_ready <= 1'b0;
         coh_aw_ready  <= 1'b0;
         last_coh      <= 1'b0;
      end else begin
         core_held     <= core_take | (core_held & ~(grant & core_win));
         coh_held      <= coh_take | (coh_held & ~(grant & coh_win));
         core_aw_ready <= ~(core_take | (core_held & ~(grant & core_win)));
         if (coherency_port_clk_en) begin
            // Ready changes only on enabled edges of the slave port
            coh_aw_ready <= ~(coh_take | (coh_held & ~(grant & coh_win)));
         end else if (coh_aw_ready && coh_held) begin
            coh_aw_ready <= 1'b0;
         end
         if (grant) begin
            last_coh <= coh_win;
         end
      end
   end

   // Per-port issue counters, wrap silently
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         issued0 <= 16'h0000;
         issued1 <= 16'h0000;
      end else if (grant) begin
         if (want_one) begin
            issued1 <= issued1 + 16'h0001;
         end else begin
            issued0 <= issued0 + 16'h0001;
         end
      end
   end

   // *****
   // Master port stages
   // *****
   wire [PAYLOAD_W-1:0] m0_payload;
   wire [PAYLOAD_W-1:0] m1_payload;

   // Ratios set entirely by the system's enables on each port
   master_port_stage #(.PAYLOAD_W(PAYLOAD_W)) u_port0 (
      .clk          (clk),
      .arst_n       (arst_n),
      .in_clk_en    (port0_input_clk_en),
      .out_clk_en   (port0_output_clk_en),
      .load_valid   (grant & ~want_one),
      .load_payload (sel_payload),
      .load_ready   (load0_ready),
      .port_valid   (m0_aw_valid),
      .port_payload (m0_payload),
      .port_ready   (m0_aw_ready)
   );

   master_port_stage #(.PAYLOAD_W(PAYLOAD_W)) u_port1 (
      .clk          (clk),
      .arst_n       (arst_n),
      .in_clk_en    (port1_input_clk_en),
      .out_clk_en   (port1_output_clk_en),
      .load_valid   (grant & want_one),
      .load_payload (sel_payload),
      .load_ready   (load1_ready),
      .port_valid   (m1_aw_valid),
      .port_payload (m1_payload),
      .port_ready   (m1_aw_ready)
   );

   // Unpack stage flops onto the port fields
   assign m0_aw_addr         = m0_payload[PAYLOAD_W-1 -: ADDR_W];
   assign m0_write_id        = m0_payload[16:11];
   assign m0_write_user_bits = m0_payload[10:2];
   assign m0_aw_lock         = m0_payload[1:0];
   assign m1_aw_addr         = m1_payload[PAYLOAD_W-1 -: ADDR_W];
   assign m1_write_id        = m1_payload[16:11];
   assign m1_write_user_bits = m1_payload[10:2];
   assign m1_aw_lock         = m1_payload[1:0];

endmodule // write_route

`default_nettype wire

/* tb/far_slave.sv */
// Slave end of one master port: write address ready with random stalls.
// Assumes the bench supplies the port's input clock enable.
`timescale 1ns/1ps
`default_nettype none
module far_slave (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_en,
   output var logic ready
);
   // Ready moves only on the port's enabled edges
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) ready <= 1'b0;
      else if (in_en) ready <= ($urandom % 3) != 0;
   end
endmodule : far_slave
`default_nettype wire

/* tb/write_route_monitor.sv */
// Checker for write_route master ports: enable timing and source fields.
// Assumes it is bound to write_route and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module write_route_monitor (
   input wire logic       clk, arst_n, core_aw_valid, core_aw_ready, coh_aw_valid, coh_aw_ready,
   input wire logic       coherency_port_clk_en, m0_aw_valid, m0_aw_ready, m1_aw_valid, m1_aw_ready,
   input wire logic       port0_input_clk_en, port0_output_clk_en,
   input wire logic       port1_input_clk_en, port1_output_clk_en,
   input wire logic [5:0] m0_write_id, m1_write_id,
   input wire logic [8:0] m0_write_user_bits, m1_write_user_bits
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Ports move only on enabled edges and hold until taken
   property p_out0; !port0_output_clk_en |=> $stable({m0_aw_valid, m0_write_user_bits}); endproperty
   a_out0: assert property (p_out0) else $error("port zero moved off enable");
   property p_out1; !port1_output_clk_en |=> $stable({m1_aw_valid, m1_write_user_bits}); endproperty
   a_out1: assert property (p_out1) else $error("port one moved off enable");
   property p_hold0; m0_aw_valid && !(m0_aw_ready && port0_input_clk_en) |=> m0_aw_valid; endproperty
   a_hold0: assert property (p_hold0) else $error("port zero dropped untaken");
   property p_hold1; m1_aw_valid && !(m1_aw_ready && port1_input_clk_en) |=> m1_aw_valid; endproperty
   a_hold1: assert property (p_hold1) else $error("port one dropped untaken");
   // Coherency writes: user 8:5 zero, id 1:0 zero
   property p_coh0; m0_aw_valid && m0_write_id[2] |-> {m0_write_user_bits[8:5], m0_write_id[1:0]} == 6'h0; endproperty
   a_coh0: assert property (p_coh0) else $error("port zero coherency fields");
   property p_coh1; m1_aw_valid && m1_write_id[2] |-> {m1_write_user_bits[8:5], m1_write_id[1:0]} == 6'h0; endproperty
   a_coh1: assert property (p_coh1) else $error("port one coherency fields");
   // Every taken request leaves with its source bit
   property p_core; core_aw_valid && core_aw_ready |-> ##[1:40] (m0_aw_valid && !m0_write_id[2] || m1_aw_valid && !m1_write_id[2]); endproperty
   a_core: assert property (p_core) else $error("core request not issued");
   property p_cohi; coh_aw_valid && coh_aw_ready && coherency_port_clk_en |-> ##[1:40] (m0_aw_valid && m0_write_id[2] || m1_aw_valid && m1_write_id[2]); endproperty
   a_cohi: assert property (p_cohi) else $error("coherency request not issued");
   c_m0: cover property (m0_aw_valid && m0_aw_ready && port0_input_clk_en);
   c_m1: cover property (m1_aw_valid && m1_aw_ready && port1_input_clk_en);
   c_coh: cover property (coh_aw_valid && coh_aw_ready && coherency_port_clk_en);
endmodule : write_route_monitor
bind write_route write_route_monitor i_mon (.*);
`default_nettype wire

/* tb/write_route_tb.sv */
// Bench for write_route: straps, routing modes, user bits and ids.
// Assumes far_slave partners and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module write_route_tb;
   logic        clk, arst_n, addr_filter_enable_pin, core_aw_valid, core_aw_ready, coh_aw_valid;
   logic        coh_aw_ready, core_aw_shared, core_aw_early_resp, core_aw_zero_line, got;
   logic        core_aw_clean_evict, core_aw_l1_evict, coherency_port_clk_en, m0_aw_valid;
   logic        m1_aw_valid, m0_aw_ready, m1_aw_ready, port0_input_clk_en, port0_output_clk_en;
   logic        port1_input_clk_en, port1_output_clk_en, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] addr_filter_low_pin, addr_filter_high_pin, core_aw_addr, coh_aw_addr, m0_aw_addr;
   logic [31:0] m1_aw_addr, s_axi_wdata, s_axi_rdata, rdat, ctl, a;
   logic [1:0]  core_aw_cpu, core_aw_lock, coh_aw_lock, m0_aw_lock, m1_aw_lock, s_axi_bresp;
   logic [1:0]  s_axi_rresp, resp;
   logic [2:0]  core_aw_kind, coh_aw_id;
   logic [3:0]  core_aw_attr, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [4:0]  coherency_port_write_user_in;
   logic [5:0]  m0_write_id, m1_write_id;
   logic [8:0]  m0_write_user_bits, m1_write_user_bits;
   logic [49:0] seen;
   int          num_errors, num_checks, ph, n0, n1;
   bit   [3:0]  attrs [6] = '{4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hf};
   bit   [31:0] modes [4] = '{32'h2, 32'h8, 32'ha, 32'h0};
   write_route i_dut (.*);
   far_slave i_s0 (.clk(clk), .arst_n(arst_n), .in_en(port0_input_clk_en), .ready(m0_aw_ready));
   far_slave i_s1 (.clk(clk), .arst_n(arst_n), .in_en(port1_input_clk_en), .ready(m1_aw_ready));
   initial begin clk = 0; forever #5 clk = ~clk; end
   // Port zero at 1.5 ratio, port one and coherency port at 2:1
   always @(posedge clk) begin
      ph <= ph + 1;
      {port0_input_clk_en, port0_output_clk_en} <= {2{ph % 3 != 1}};
      {port1_input_clk_en, port1_output_clk_en, coherency_port_clk_en} <= {3{ph[0]}};
   end
   // Record each beat with the port that carried it
   always @(posedge clk) begin
      if (m0_aw_valid && m0_aw_ready && port0_input_clk_en) begin
         seen = {1'b0, m0_write_id, m0_write_user_bits, m0_aw_lock, m0_aw_addr}; got = 1;
      end
      if (m1_aw_valid && m1_aw_ready && port1_input_clk_en) begin
         seen = {1'b1, m1_write_id, m1_write_user_bits, m1_aw_lock, m1_aw_addr}; got = 1;
      end
   end
   task chk(input logic [49:0] g, input logic [49:0] e);
      num_checks++;
      if (g !== e) begin num_errors++; $display("mismatch at %0t: got %h want %h", $time, g, e); end
   endtask
   // Expected port: filter first, then lock, then device forcing
   function bit pick(input [31:0] ad, input [1:0] lk, input [3:0] at);
      if (ctl[1]) return ad >= addr_filter_low_pin && ad <= addr_filter_high_pin;
      if (lk != 0) return 0;
      if (ctl[3] && at == 4'h1) return 0;
      return ad[5];
   endfunction
   task wr(input [3:0] ad, input [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp; s_axi_bready <= 0;
   endtask
   task rd(input [3:0] ad);
      @(posedge clk);
      s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata; s_axi_rready <= 0;
   endtask
   task req(input bit coh, input [31:0] ad, input [1:0] lk, input [3:0] at);
      logic [8:0] u;
      logic [5:0] id;
      u = 9'($urandom); id = 6'($urandom); u[4:1] = at;
      @(posedge clk);
      got = 0;
      if (coh) begin
         coh_aw_addr <= ad; coh_aw_lock <= lk; coh_aw_id <= id[5:3]; coh_aw_valid <= 1;
         coherency_port_write_user_in <= u[4:0];
         u[8:5] = 4'h0; id[2:0] = 3'b100;
      end else begin
         core_aw_addr <= ad; core_aw_lock <= lk; core_aw_attr <= at; core_aw_shared <= u[0];
         {core_aw_early_resp, core_aw_zero_line, core_aw_clean_evict, core_aw_l1_evict} <= u[8:5];
         core_aw_kind <= id[5:3]; core_aw_cpu <= id[1:0]; core_aw_valid <= 1; id[2] = 0;
      end
      do @(posedge clk); while (!(coh ? coh_aw_ready && coherency_port_clk_en : core_aw_ready));
      coh_aw_valid <= 0; core_aw_valid <= 0;
      while (!got) @(posedge clk);
      chk(seen, {pick(ad, lk, at), id, u, lk, ad});
      if (pick(ad, lk, at)) n1++; else n0++;
   endtask
   task complete_run;
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin #500000; num_errors++; complete_run; end
   initial begin
      void'($urandom(32'ha1f8cabc));
      {arst_n, core_aw_valid, coh_aw_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, port0_input_clk_en, port0_output_clk_en, ctl} = 0;
      {port1_input_clk_en, port1_output_clk_en, coherency_port_clk_en, core_aw_addr} = 0;
      {coh_aw_addr, s_axi_wdata, core_aw_cpu, core_aw_lock, coh_aw_lock, core_aw_kind} = 0;
      {coh_aw_id, core_aw_attr, s_axi_awaddr, s_axi_araddr, coherency_port_write_user_in} = 0;
      {core_aw_shared, core_aw_early_resp, core_aw_zero_line, core_aw_clean_evict} = 0;
      core_aw_l1_evict = 0; s_axi_wstrb = 4'hf; addr_filter_enable_pin = 1;
      addr_filter_low_pin = 32'h1000; addr_filter_high_pin = 32'h1fff;
      repeat (5) @(posedge clk);
      arst_n <= 1;
      repeat (6) @(posedge clk);
      rd(4'h0); chk(rdat, 32'h2);
      rd(4'h4); chk(rdat, addr_filter_low_pin);
      rd(4'h8); chk(rdat, addr_filter_high_pin);
      wr(4'hc, 32'h1); chk(resp, 2'b10);
      foreach (modes[m]) begin
         wr(4'h0, modes[m]); ctl = modes[m];
         rd(4'h0); chk(rdat, ctl);
         repeat (24) begin
            case ($urandom % 5)
               0: a = 32'h1000; 1: a = 32'h1fff; 2: a = 32'h0fff; 3: a = 32'h2000;
               default: a = $urandom;
            endcase
            req($urandom % 2, a, 2'($urandom % 3), attrs[$urandom % 6]);
         end
      end
      rd(4'hc); chk(rdat, {n1[15:0], n0[15:0]});
      complete_run;
   end
endmodule : write_route_tb
`default_nettype wire
